// *** design/dct_pkg.sv ***
// Constants for the dual countdown timer register block.
// Assumes one 200 MHz system clock and byte-wide host register access.
package dct_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_RUN = 8'h0E;
	localparam logic [7:0] ADDR_A_RLD_HI = 8'h10;
	localparam logic [7:0] ADDR_A_RLD_LO = 8'h11;
	localparam logic [7:0] ADDR_A_CNT_HI = 8'h12;
	localparam logic [7:0] ADDR_A_CNT_LO = 8'h13;
	localparam logic [7:0] ADDR_B_CFG = 8'h14;
	localparam logic [7:0] ADDR_B_RLD_HI = 8'h15;
	localparam logic [7:0] ADDR_B_RLD_LO = 8'h16;
	localparam logic [7:0] ADDR_B_CNT_HI = 8'h17;
	localparam logic [7:0] ADDR_B_CNT_LO = 8'h18;

	// Field positions
	localparam int CFG_STOP_RX_BIT = 7;
	localparam int CFG_START_HI = 5;
	localparam int CFG_START_LO = 4;
	localparam int CFG_RESTART_BIT = 3;
	localparam int CFG_SRC_HI = 1;
	localparam int CFG_SRC_LO = 0;
	localparam int RUN_A_BIT = 4;
	localparam int RUN_B_BIT = 5;
	localparam int MASK_A_BIT = 0;
	localparam int MASK_B_BIT = 1;

	// Writable config bits; bits 6 and 2 are reserved
	localparam logic [7:0] CFG_WR_MASK = 8'hBB;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	typedef enum logic [1:0] {
		START_NONE = 2'h0,
		START_TX_END = 2'h1,
		START_TRIM = 2'h2,
		START_TRIM_UF = 2'h3
	} dct_start_e;

	typedef enum logic [1:0] {
		SRC_FAST = 2'h0,
		SRC_SLOW = 2'h1,
		SRC_TIMER_A = 2'h2,
		SRC_TIMER_C = 2'h3
	} dct_src_e;

	// Tick rates: 13.56 MHz by phase accumulation, 211.875 kHz as 13.56 MHz / 64
	localparam int CLK_KHZ = 200000;
	localparam int FAST_KHZ = 13560;
	localparam int SLOW_KHZ_X1000 = 211875;
	localparam int SLOW_DIV = (FAST_KHZ * 1000) / SLOW_KHZ_X1000;
	localparam int ACC_W = 18;
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(FAST_KHZ);
	localparam logic [5:0] SLOW_LAST = 6'(SLOW_DIV - 1);

endpackage

// *** design/dct_tick_if.sv ***
// Carrier for the counting-rate enables between rate generator and timer logic.
// Both enables are one-cycle pulses on the system clock.
`timescale 1ns/1ps
interface dct_tick_if;
	logic fast_tick;
	logic slow_tick;
	modport src(output fast_tick, output slow_tick);
	modport dst(input fast_tick, input slow_tick);
endinterface

// *** design/dct_rate_gen.sv ***
// Rate generator making the 13.56 MHz and 211.875 kHz tick enables.
// Assumes the system clock runs at the rate named in the package.
`timescale 1ns/1ps
module dct_rate_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Tick enables
	dct_tick_if.src ticks
);

	logic [dct_pkg::ACC_W-1:0] acc_reg;
	logic [dct_pkg::ACC_W-1:0] acc_next;
	logic [dct_pkg::ACC_W-1:0] acc_sum;
	logic [5:0] div_reg;
	logic fast_reg;
	logic slow_reg;
	logic fast_next;

	// Fractional accumulation keeps the long-term rate exact with jitter of one cycle
	assign acc_sum = acc_reg + dct_pkg::ACC_STEP;
	assign fast_next = (acc_sum >= dct_pkg::ACC_MOD);
	assign acc_next = fast_next ? acc_sum - dct_pkg::ACC_MOD : acc_sum;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= '0;
			div_reg <= '0;
			fast_reg <= 1'b0;
			slow_reg <= 1'b0;
		end else begin
			acc_reg <= acc_next;
			fast_reg <= fast_next;
			slow_reg <= fast_next && (div_reg == dct_pkg::SLOW_LAST);
			if (fast_next)
				div_reg <= div_reg + 6'h01;
		end
	end

	assign ticks.fast_tick = fast_reg;
	assign ticks.slow_tick = slow_reg;

	// Fast rate is below half the clock, so ticks never touch
	tick_gap_a: assert property (@(posedge clk) disable iff (!arst_n)
		fast_reg |=> !fast_reg) else $error("fast ticks back to back");
	slow_in_fast_a: assert property (@(posedge clk) disable iff (!arst_n)
		slow_reg |-> fast_reg) else $error("slow tick off the fast grid");

endmodule

// *** design/dct_down_counter.sv ***
// One 16-bit down counter with reload, start, stop and underflow pulse.
// Assumes start, stop and tick are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module dct_down_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic start,
	input wire logic stop,
	input wire logic tick,
	input wire logic reload_on_zero,
	input wire logic [15:0] reload,
	// State
	output logic [15:0] count,
	output logic running,
	output logic underflow
);

	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic run_reg;
	logic run_next;
	logic uf_reg;
	logic step;
	logic at_zero;

	assign step = run_reg && tick && !start && !stop;
	assign at_zero = (count_reg == dct_pkg::COUNT_ZERO);
	// Start has priority: a stop in the same cycle loses
	assign count_next = start ? reload :
		(step && at_zero && reload_on_zero) ? reload :
		(step && !at_zero) ? count_reg - dct_pkg::COUNT_ONE : count_reg;
	assign run_next = start ? 1'b1 : stop ? 1'b0 :
		(step && at_zero && !reload_on_zero) ? 1'b0 : run_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
			run_reg <= 1'b0;
			uf_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			run_reg <= run_next;
			uf_reg <= step && at_zero;
		end
	end

	assign count = count_reg;
	assign running = run_reg;
	assign underflow = uf_reg;

endmodule

// *** design/dct_top.sv ***
// Dual countdown timer register block: timer A and timer B with host byte registers.
// Assumes host, receive and transmit events are single-cycle pulses on clk.
// What this block does
// - A start event loads timer A's counter from its two reload bytes.
// - Writing reload bytes leaves a running count alone until next start or timer B reload on zero.
// - Timer A upper count byte reads live; host avoids reading during reception.
// - Timer A lower count byte reads live; host avoids reading during reception.
// - Stop-on-receive bit stops timer B after first four received bits.
// - Oscillator trimming modes make timer B ignore stop-on-receive.
// - Autostart 00 means no autostart; 01 starts timer B at transmit end.
// - Autostart 10/11 trim: rising edge starts/stops; 10 without, 11 with underflow.
// - With reload-on-zero set, timer B reloads at zero and keeps counting.
// - With reload-on-zero clear, timer B halts at zero until next start.
// - Timer B underflows set the timer B underflow flag in every autostart mode but 10.
// - Source 00 counts at 13.56 MHz, 01 at 211.875 kHz.
// - Source 10 counts timer A underflows, 11 counts timer C underflows.
// - Timer B reload bytes are read/write and load the counter on start.
// - Timer B upper count byte reads live and read-only.
// - A run register write changes only the run bits whose matching mask bit is written one.
// - Timer B lower count byte reads live and read-only.
`timescale 1ns/1ps
module dct_top (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Host register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Frontend events
	input wire logic tx_end,
	input wire logic rx_first_bits,
	input wire logic trim_edge,
	input wire logic timer_c_underflow,
	input wire logic underflow_flag_clear,
	// Status
	output logic timer_b_underflow_flag,
	output logic timer_a_running,
	output logic timer_b_running
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [7:0] a_rld_hi_reg;
	logic [7:0] a_rld_lo_reg;
	logic [7:0] b_cfg_reg;
	logic [7:0] b_rld_hi_reg;
	logic [7:0] b_rld_lo_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic flag_reg;
	logic flag_next;

	wire wr_run = reg_wr && (reg_addr == dct_pkg::ADDR_RUN);
	wire wr_a_hi = reg_wr && (reg_addr == dct_pkg::ADDR_A_RLD_HI);
	wire wr_a_lo = reg_wr && (reg_addr == dct_pkg::ADDR_A_RLD_LO);
	wire wr_b_cfg = reg_wr && (reg_addr == dct_pkg::ADDR_B_CFG);
	wire wr_b_hi = reg_wr && (reg_addr == dct_pkg::ADDR_B_RLD_HI);
	wire wr_b_lo = reg_wr && (reg_addr == dct_pkg::ADDR_B_RLD_LO);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			a_rld_hi_reg <= dct_pkg::REG_RESET;
			a_rld_lo_reg <= dct_pkg::REG_RESET;
			b_cfg_reg <= dct_pkg::REG_RESET;
			b_rld_hi_reg <= dct_pkg::REG_RESET;
			b_rld_lo_reg <= dct_pkg::REG_RESET;
		end else begin
			// Reload bytes feed the counters at a start event, and timer B's also at a reload on zero
			if (wr_a_hi)
				a_rld_hi_reg <= reg_wdata;
			if (wr_a_lo)
				a_rld_lo_reg <= reg_wdata;
			if (wr_b_cfg)
				b_cfg_reg <= reg_wdata & dct_pkg::CFG_WR_MASK;
			if (wr_b_hi)
				b_rld_hi_reg <= reg_wdata;
			if (wr_b_lo)
				b_rld_lo_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Config decode and start/stop events

	wire b_stop_rx = b_cfg_reg[dct_pkg::CFG_STOP_RX_BIT];
	wire b_restart = b_cfg_reg[dct_pkg::CFG_RESTART_BIT];
	wire [1:0] b_mode_raw = b_cfg_reg[dct_pkg::CFG_START_HI:dct_pkg::CFG_START_LO];
	wire [1:0] b_src_raw = b_cfg_reg[dct_pkg::CFG_SRC_HI:dct_pkg::CFG_SRC_LO];
	dct_pkg::dct_start_e b_mode;
	dct_pkg::dct_src_e b_src;
	assign b_mode = dct_pkg::dct_start_e'(b_mode_raw);
	assign b_src = dct_pkg::dct_src_e'(b_src_raw);

	wire [15:0] a_reload = {a_rld_hi_reg, a_rld_lo_reg};
	wire [15:0] b_reload = {b_rld_hi_reg, b_rld_lo_reg};
	wire [15:0] a_count;
	wire [15:0] b_count;
	wire a_running;
	wire b_running;
	wire a_uf;
	wire b_uf;

	// Mask bits pick which run bits a write may touch
	wire a_run_ctl = wr_run && reg_wdata[dct_pkg::MASK_A_BIT];
	wire b_run_ctl = wr_run && reg_wdata[dct_pkg::MASK_B_BIT];
	wire a_start = a_run_ctl && reg_wdata[dct_pkg::RUN_A_BIT];
	wire a_stop = a_run_ctl && !reg_wdata[dct_pkg::RUN_A_BIT];

	wire b_trim = (b_mode == dct_pkg::START_TRIM) || (b_mode == dct_pkg::START_TRIM_UF);
	// Trimming: each rising edge of the slow oscillator toggles run state
	wire trim_toggle = b_trim && trim_edge;
	wire tx_start = (b_mode == dct_pkg::START_TX_END) && tx_end;
	wire rx_stop = b_stop_rx && !b_trim && rx_first_bits;
	wire b_start = (b_run_ctl && reg_wdata[dct_pkg::RUN_B_BIT]) || tx_start ||
		(trim_toggle && !b_running);
	wire b_stop = (b_run_ctl && !reg_wdata[dct_pkg::RUN_B_BIT]) || rx_stop ||
		(trim_toggle && b_running);

	////////////////////////////////////////////////////////////////////////////////
	// Counting sources

	dct_tick_if tick_if ();

	dct_rate_gen u_rate (
		.clk(clk),
		.arst_n(arst_n),
		.ticks(tick_if.src)
	);

	wire b_tick = (b_src == dct_pkg::SRC_FAST) ? tick_if.fast_tick :
		(b_src == dct_pkg::SRC_SLOW) ? tick_if.slow_tick :
		(b_src == dct_pkg::SRC_TIMER_A) ? a_uf : timer_c_underflow;

	// Timer A has no control byte here: it counts at 13.56 MHz and halts at zero
	dct_down_counter u_timer_a (
		.clk(clk),
		.arst_n(arst_n),
		.start(a_start),
		.stop(a_stop),
		.tick(tick_if.fast_tick),
		.reload_on_zero(1'b0),
		.reload(a_reload),
		.count(a_count),
		.running(a_running),
		.underflow(a_uf)
	);

	dct_down_counter u_timer_b (
		.clk(clk),
		.arst_n(arst_n),
		.start(b_start),
		.stop(b_stop),
		.tick(b_tick),
		.reload_on_zero(b_restart),
		.reload(b_reload),
		.count(b_count),
		.running(b_running),
		.underflow(b_uf)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Underflow flag and read path

	// Trim without underflow keeps the flag quiet; a set beats a same-cycle clear
	wire flag_set = b_uf && (b_mode != dct_pkg::START_TRIM);
	assign flag_next = flag_set || (flag_reg && !underflow_flag_clear);

	wire [7:0] run_rd = {2'b00, b_running, a_running, 4'h0};
	// Counts are live; a read during reception may see a torn pair of bytes
	always_comb begin
		case (reg_addr)
			dct_pkg::ADDR_RUN: rdata_next = run_rd;
			dct_pkg::ADDR_A_RLD_HI: rdata_next = a_rld_hi_reg;
			dct_pkg::ADDR_A_RLD_LO: rdata_next = a_rld_lo_reg;
			dct_pkg::ADDR_A_CNT_HI: rdata_next = a_count[15:8];
			dct_pkg::ADDR_A_CNT_LO: rdata_next = a_count[7:0];
			dct_pkg::ADDR_B_CFG: rdata_next = b_cfg_reg;
			dct_pkg::ADDR_B_RLD_HI: rdata_next = b_rld_hi_reg;
			dct_pkg::ADDR_B_RLD_LO: rdata_next = b_rld_lo_reg;
			dct_pkg::ADDR_B_CNT_HI: rdata_next = b_count[15:8];
			dct_pkg::ADDR_B_CNT_LO: rdata_next = b_count[7:0];
			default: rdata_next = dct_pkg::REG_RESET;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= dct_pkg::REG_RESET;
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
			if (reg_rd)
				rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign timer_b_underflow_flag = flag_reg;
	assign timer_a_running = a_running;
	assign timer_b_running = b_running;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_load_a: assert property (a_start |=> a_running && a_count == $past(a_reload))
		else $error("timer A start did not load reload value");
	b_load_a: assert property (b_start |=> b_running && b_count == $past(b_reload))
		else $error("timer B start did not load reload value");
	rld_hold_a: assert property ((wr_a_hi || wr_a_lo) && a_running
		&& !a_start && !a_stop && !tick_if.fast_tick |=> a_count == $past(a_count))
		else $error("reload write disturbed timer A count");
	rld_hold_b_a: assert property ((wr_b_hi || wr_b_lo) && b_running
		&& !b_start && !b_stop && !b_tick |=> b_count == $past(b_count))
		else $error("reload write disturbed timer B count");
	a_step_a: assert property (a_running && tick_if.fast_tick && !a_start && !a_stop
		&& a_count != dct_pkg::COUNT_ZERO |=> a_count == $past(a_count) - dct_pkg::COUNT_ONE)
		else $error("timer A did not step down on a tick");
	b_step_a: assert property (b_running && b_tick && !b_start && !b_stop
		&& b_count != dct_pkg::COUNT_ZERO |=> b_count == $past(b_count) - dct_pkg::COUNT_ONE)
		else $error("timer B did not step down on a tick");
	a_uf_a: assert property (a_running && tick_if.fast_tick && !a_start && !a_stop
		&& a_count == dct_pkg::COUNT_ZERO |=> a_uf && !a_running)
		else $error("timer A did not underflow and halt at zero");
	cnt_read_a: assert property (reg_rd && reg_addr == dct_pkg::ADDR_A_CNT_LO
		|=> reg_rdata == $past(a_count[7:0]))
		else $error("timer A low count read wrong");
	a_hi_read_a: assert property (reg_rd && reg_addr == dct_pkg::ADDR_A_CNT_HI
		|=> reg_rdata == $past(a_count[15:8]))
		else $error("timer A high count read wrong");
	b_hi_read_a: assert property (reg_rd && reg_addr == dct_pkg::ADDR_B_CNT_HI
		|=> reg_rdata == $past(b_count[15:8]))
		else $error("timer B high count read wrong");
	b_lo_read_a: assert property (reg_rd && reg_addr == dct_pkg::ADDR_B_CNT_LO
		|=> reg_rdata == $past(b_count[7:0]))
		else $error("timer B low count read wrong");
	rx_stop_a: assert property (b_running && b_stop_rx && !b_trim && rx_first_bits
		&& !b_start |=> !b_running)
		else $error("timer B not stopped on receive");
	rx_free_a: assert property (b_running && !b_stop_rx && rx_first_bits
		&& !trim_edge && !b_run_ctl
		&& !(b_tick && b_count == dct_pkg::COUNT_ZERO) |=> b_running)
		else $error("timer B stopped on receive with stop bit clear");
	trim_rx_a: assert property (b_running && b_trim && rx_first_bits && !trim_edge
		&& !b_run_ctl && !(b_tick && b_count == dct_pkg::COUNT_ZERO) |=> b_running)
		else $error("trim mode honoured stop on receive");
	tx_start_a: assert property (tx_start |=> b_running && b_count == $past(b_reload))
		else $error("timer B not started at transmit end");
	no_auto_a: assert property (b_mode == dct_pkg::START_NONE && tx_end && !b_running
		&& !b_run_ctl |=> !b_running)
		else $error("timer B started with autostart off");
	trim_start_a: assert property (b_trim && trim_edge && !b_running
		|=> b_running && b_count == $past(b_reload))
		else $error("trim edge did not start timer B");
	trim_stop_a: assert property (b_trim && trim_edge && b_running && !b_run_ctl
		|=> !b_running)
		else $error("trim edge did not stop timer B");
	trim_quiet_a: assert property (b_mode == dct_pkg::START_TRIM && !flag_reg
		|=> !flag_reg)
		else $error("trim without underflow raised the flag");
	restart_a: assert property (b_running && b_restart && b_tick
		&& b_count == dct_pkg::COUNT_ZERO && !b_start && !b_stop
		|=> b_running && b_count == $past(b_reload) && b_uf)
		else $error("timer B did not reload at zero");
	halt_a: assert property (b_running && !b_restart && b_tick
		&& b_count == dct_pkg::COUNT_ZERO && !b_start && !b_stop
		|=> !b_running ##1 !b_running || $past(b_start))
		else $error("timer B did not halt at zero");
	flag_set_a: assert property (b_uf && b_mode != dct_pkg::START_TRIM |=> flag_reg)
		else $error("underflow flag not set");
	flag_clr_a: assert property (flag_reg && underflow_flag_clear && !b_uf
		|=> !flag_reg)
		else $error("underflow flag not cleared");
	idle_hold_a: assert property (b_running && !b_tick && !b_start && !b_stop
		|=> b_count == $past(b_count))
		else $error("timer B moved without a tick");
	fast_src_a: assert property (b_src == dct_pkg::SRC_FAST
		|-> b_tick == tick_if.fast_tick)
		else $error("fast source not selected");
	slow_src_a: assert property (b_src == dct_pkg::SRC_SLOW
		|-> b_tick == tick_if.slow_tick)
		else $error("slow source not selected");
	cascade_a: assert property (b_src == dct_pkg::SRC_TIMER_A && a_uf && b_running
		&& !b_start && !b_stop |=> b_count != $past(b_count) || b_uf)
		else $error("timer A underflow not counted");
	ext_src_a: assert property (b_src == dct_pkg::SRC_TIMER_C && timer_c_underflow
		&& b_running && !b_start && !b_stop |=> b_count != $past(b_count) || b_uf)
		else $error("timer C underflow not counted");
	rsvd_zero_a: assert property (b_cfg_reg[6] == 1'b0 && b_cfg_reg[2] == 1'b0)
		else $error("reserved config bits not zero");
	run_mask_a: assert property (wr_run && !reg_wdata[dct_pkg::MASK_A_BIT] && a_running
		&& !(tick_if.fast_tick && a_count == dct_pkg::COUNT_ZERO) |=> a_running)
		else $error("unmasked run write stopped timer A");
	b_mask_a: assert property (wr_run && !reg_wdata[dct_pkg::MASK_B_BIT]
		&& !b_running && !tx_start && !trim_toggle |=> !b_running)
		else $error("unmasked run write started timer B");

	restart_c: cover property (b_uf && b_restart ##1 b_running);
	halt_c: cover property (b_uf && !b_restart ##1 !b_running);
	trim_c: cover property (b_trim && trim_edge && b_running ##1 !b_running);
	rx_stop_c: cover property (rx_stop && b_running ##1 !b_running);
	cascade_c: cover property (b_src == dct_pkg::SRC_TIMER_A && a_uf && b_running);

endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the dual countdown timer register block.
// Drives the host port and frontend events of dct_top directly at the falling clock edge.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tx_end = 1'b0;
	logic rx_first_bits = 1'b0;
	logic trim_edge = 1'b0;
	logic timer_c_underflow = 1'b0;
	logic underflow_flag_clear = 1'b0;
	logic [7:0] reg_rdata;
	logic timer_b_underflow_flag;
	logic timer_a_running;
	logic timer_b_running;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] rnd [4];
	logic [7:0] cfg_tab [5] = '{8'h80, 8'h90, 8'h10, 8'hA0, 8'hB0};
	logic [7:0] c;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	dct_top dut (
		.clk(clk),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.tx_end(tx_end),
		.rx_first_bits(rx_first_bits),
		.trim_edge(trim_edge),
		.timer_c_underflow(timer_c_underflow),
		.underflow_flag_clear(underflow_flag_clear),
		.timer_b_underflow_flag(timer_b_underflow_flag),
		.timer_a_running(timer_a_running),
		.timer_b_running(timer_b_running)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Strobes stay high between back-to-back calls; idle() drops them
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_rd = 1'b0;
		reg_wr = 1'b1;
		@(negedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		reg_addr = a;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		exp_q.push_back(want);
		@(negedge clk);
	endtask

	task automatic idle(input int n);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (n) @(negedge clk);
	endtask

	// Event index: 0 tx end, 1 receive bits, 2 trim edge, 3 timer C underflow, 4 flag clear
	task automatic ev(input int k);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		{underflow_flag_clear, timer_c_underflow, trim_edge, rx_first_bits, tx_end} = 5'(1 << k);
		@(negedge clk);
		{underflow_flag_clear, timer_c_underflow, trim_edge, rx_first_bits, tx_end} = 5'h00;
		@(negedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Read data lands one edge after the strobe, so compare on the following falling edge
	always @(posedge clk) rd_seen <= reg_rd;

	always @(negedge clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				check(reg_rdata, 8'hXX);
			end else begin
				check(reg_rdata, exp_q.pop_front());
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			fail_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h1c99));
		repeat (20) @(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		// Reset state, unmapped neighbours included
		for (int a = 'h0E; a <= 'h1A; a++) rd(8'(a), 8'h00);
		idle(2);
		check(timer_a_running, 1'b0);
		check(timer_b_running, 1'b0);
		// Reload bytes read back; count bytes and reserved bits ignore writes
		for (int i = 0; i < 4; i++) rnd[i] = 8'($urandom);
		for (int i = 0; i < 4; i++) wr(i < 2 ? 8'(8'h10 + i) : 8'(8'h13 + i), rnd[i]);
		wr(8'h14, 8'hFF);
		wr(8'h12, 8'h55);
		wr(8'h17, 8'h55);
		for (int i = 0; i < 4; i++) rd(i < 2 ? 8'(8'h10 + i) : 8'(8'h13 + i), rnd[i]);
		rd(8'h14, 8'hBB);
		rd(8'h12, 8'h00);
		rd(8'h17, 8'h00);
		// Timer A: run bit without mask, start, reload rewritten while counting
		wr(8'h10, 8'h12);
		wr(8'h11, 8'h80);
		wr(8'h0E, 8'h10);
		idle(2);
		check(timer_a_running, 1'b0);
		wr(8'h0E, 8'h11);
		wr(8'h0E, 8'h02);
		idle(16);
		check(timer_a_running, 1'b1);
		wr(8'h10, 8'h56);
		wr(8'h11, 8'h34);
		wr(8'h0E, 8'h01);
		rd(8'h12, 8'h12);
		// Start then stop at once: start and stop both beat a tick
		wr(8'h0E, 8'h11);
		wr(8'h0E, 8'h01);
		rd(8'h12, 8'h56);
		rd(8'h13, 8'h34);
		idle(2);
		check(timer_a_running, 1'b0);
		// Count sources with zero reloads: first tick of the source underflows timer B
		for (int i = 0; i < 4; i++) wr(8'(8'h10 + (i < 2 ? i : i + 3)), 8'h00);
		for (int s = 0; s < 4; s++) begin
			wr(8'h14, 8'(s));
			ev(4);
			wr(8'h0E, 8'h22);
			idle(100);
			if (s != 1) check(timer_b_underflow_flag, s == 0);
			if (s == 2) wr(8'h0E, 8'h11);
			if (s == 3) ev(3);
			idle(1000);
			check(timer_b_underflow_flag, 1'b1);
			wr(8'h0E, 8'h03);
		end
		// Halt at zero versus reload on zero
		wr(8'h16, 8'h05);
		for (int r = 0; r < 2; r++) begin
			wr(8'h14, 8'(r << 3));
			ev(4);
			wr(8'h0E, 8'h22);
			idle(200);
			check(timer_b_running, r[0]);
			check(timer_b_underflow_flag, 1'b1);
			rd(8'h17, 8'h00);
			if (r == 0) rd(8'h18, 8'h00);
			wr(8'h15, 8'h00);
			wr(8'h0E, 8'h02);
		end
		// Autostart modes against receive stop, with a long count
		wr(8'h15, 8'h40);
		for (int i = 0; i < 5; i++) begin
			c = cfg_tab[i];
			wr(8'h14, c);
			ev(c[5] ? 2 : 0);
			check(timer_b_running, c[5:4] != 2'h0);
			ev(1);
			check(timer_b_running, c[5:4] != 2'h0 && c[5:4] != 2'h1 || c == 8'h10);
			if (c[5]) begin
				ev(2);
				check(timer_b_running, 1'b0);
			end
			wr(8'h0E, 8'h02);
		end
		// Trimming with and without underflow report
		wr(8'h15, 8'h00);
		wr(8'h16, 8'h00);
		for (int i = 3; i < 5; i++) begin
			c = cfg_tab[i];
			wr(8'h14, c);
			ev(4);
			ev(2);
			idle(100);
			check(timer_b_underflow_flag, c[4]);
			wr(8'h0E, 8'h02);
		end
		idle(4);
		conclude();
	end
endmodule
